//--- rbm_host_model.sv
// initiator model: AXI4-Lite master issuing read-buffer commands
`default_nettype none
module rbm_host_model (
	input  wire logic        clk,
	output logic [7:0]       awaddr,
	output logic             awvalid,
	input  wire logic        awready,
	output logic [31:0]      wdata,
	output logic [3:0]       wstrb,
	output logic             wvalid,
	input  wire logic        wready,
	input  wire logic [1:0]  bresp,
	input  wire logic        bvalid,
	output logic             bready,
	output logic [7:0]       araddr,
	output logic             arvalid,
	input  wire logic        arready,
	input  wire logic [31:0] rdata,
	input  wire logic [1:0]  rresp,
	input  wire logic        rvalid,
	output logic             rready
);
	// idle bus from time zero
	initial
	begin
		{awaddr, awvalid, wdata, wvalid, bready} = '0;
		{araddr, arvalid, rready} = '0;
		wstrb = 4'hF;
	end

	// one write; each channel dropped only at the edge that takes it
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
		logic awPend;
		logic wPend;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		awPend = 1'b1;
		wPend = 1'b1;
		forever
		begin
			@(posedge clk);
			if (!awPend && !wPend && bvalid)
				break;
			if (awready)
			begin
				awPend = 1'b0;
				awvalid <= 1'b0;
			end
			if (wready)
			begin
				wPend = 1'b0;
				wvalid <= 1'b0;
			end
		end
		resp = bresp;
		bready <= 1'b0;
	endtask

	// one read; data taken at the edge where rvalid is seen
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
		logic arPend;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		arPend = 1'b1;
		forever
		begin
			@(posedge clk);
			if (!arPend && rvalid)
				break;
			if (arready)
			begin
				arPend = 1'b0;
				arvalid <= 1'b0;
			end
		end
		d = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask

	// full command: fields, start, then status and transfer count
	task automatic cmd(input logic [4:0] mode, input logic [7:0] id, input logic [23:0] off,
		input logic [23:0] alloc, input logic [7:0] nex, output logic [31:0] st, output logic [31:0] xf);
		logic [1:0] r;
		if (mode == rbm_pkg::MODE_DESC)
		begin
			id = 8'h00;
			off = off & 24'hFFFE00;
		end
		wr(rbm_pkg::OFF_CDB, {16'h0000, id, 3'h0, mode}, r);
		wr(rbm_pkg::OFF_OFFSET, {8'h00, off}, r);
		wr(rbm_pkg::OFF_ALLOC, {8'h00, alloc}, r);
		wr(rbm_pkg::OFF_NEXUS, {24'h000000, nex}, r);
		wr(rbm_pkg::OFF_CTRL, 32'h00000001, r);
		rd(rbm_pkg::OFF_STATUS, st, r);
		rd(rbm_pkg::OFF_XFER, xf, r);
	endtask

	// echo write ahead of echo reads; two words then the byte count
	task automatic echo_load(input logic [31:0] w0, input logic [31:0] w1, input logic [15:0] len);
		logic [1:0] r;
		wr(rbm_pkg::OFF_ECHOWR, w0, r);
		wr(rbm_pkg::OFF_ECHOWR, w1, r);
		wr(rbm_pkg::OFF_ECHOLEN, {16'h0000, len}, r);
	endtask
endmodule
`default_nettype wire

//--- rbm_pkg.sv
// constants for the diagnostic read-buffer command handler
`default_nettype none
package rbm_pkg;
	// register byte offsets on the AXI4-Lite bus
	localparam logic [7:0] OFF_CDB     = 8'h00;
	localparam logic [7:0] OFF_OFFSET  = 8'h04;
	localparam logic [7:0] OFF_ALLOC   = 8'h08;
	localparam logic [7:0] OFF_NEXUS   = 8'h0C;
	localparam logic [7:0] OFF_CTRL    = 8'h10;
	localparam logic [7:0] OFF_STATUS  = 8'h14;
	localparam logic [7:0] OFF_XFER    = 8'h18;
	localparam logic [7:0] OFF_DATA    = 8'h1C;
	localparam logic [7:0] OFF_ECHOWR  = 8'h20;
	localparam logic [7:0] OFF_ECHOLEN = 8'h24;
	localparam logic [7:0] OFF_EHSTATE = 8'h28;
	// field positions
	localparam int CDB_MODE_LSB  = 0;
	localparam int CDB_ID_LSB    = 8;
	localparam int CTRL_START    = 0;
	localparam int ST_DONE       = 0;
	localparam int ST_CHECK      = 1;
	localparam int ST_KEY_LSB    = 8;
	localparam int ST_ASCQ_LSB   = 16;
	localparam int ST_ASC_LSB    = 24;
	localparam int EHS_NEXUS     = 0;
	localparam int EHS_SNAP      = 1;
	localparam int EHS_OWNER_LSB = 8;
	// command modes
	localparam logic [4:0] MODE_DESC      = 5'h03;
	localparam logic [4:0] MODE_ECHO      = 5'h0A;
	localparam logic [4:0] MODE_ECHO_DESC = 5'h0B;
	localparam logic [4:0] MODE_EXPANDER  = 5'h1A;
	localparam logic [4:0] MODE_ERRHIST   = 5'h1C;
	// sense data
	localparam logic [3:0] SK_NONE       = 4'h0;
	localparam logic [3:0] SK_ILLEGAL    = 4'h5;
	localparam logic [7:0] ASC_NONE      = 8'h00;
	localparam logic [7:0] ASC_INV_FIELD = 8'h24;
	localparam logic [7:0] ASC_SEQ_ERR   = 8'h2C;
	localparam logic [7:0] ASC_OP_PROG   = 8'h00;
	localparam logic [7:0] ASCQ_NONE     = 8'h00;
	localparam logic [7:0] ASCQ_OP_PROG  = 8'h16;
	// descriptor contents
	localparam logic [7:0]  OFFSET_BOUNDARY = 8'h09;
	localparam logic [23:0] DESC_LEN        = 24'h000004;
	localparam logic        ECHO_OVERWRITE  = 1'h0;
	localparam int          ECHO_OVERWRITE_SUPPORTED_FLAG_POS = 24;
	localparam logic [12:0] ECHO_CAP_ALIGN  = 13'h1FFC;
	// error history buffer identifiers
	localparam logic [7:0]  EH_DIR_LAST   = 8'h03;
	localparam logic [7:0]  EH_ANY_LO     = 8'h02;
	localparam logic [7:0]  EH_DATA_LO    = 8'h10;
	localparam logic [7:0]  EH_DATA_HI    = 8'hEF;
	localparam logic [7:0]  EH_CLR_NEXUS  = 8'hFE;
	localparam logic [7:0]  EH_CLR_ALL    = 8'hFF;
	localparam logic [23:0] EH_OFF_MAX    = 24'h00FFFF;
	localparam logic [23:0] ZERO24        = 24'h000000;
	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

//--- rbm_read_buffer.sv
// read-buffer command handler with AXI4-Lite register slave
//
// The implementer's own choices: the AXI4-Lite slave port and the placing of the registers.
`default_nettype none
module rbm_read_buffer #(
	parameter int          AW            = 8,
	parameter int          ECHO_WORDS    = 16,
	parameter logic [23:0] DBUF_CAPACITY = 24'h010000,
	parameter logic [23:0] EH_DIR_LEN    = 24'h000028,
	parameter logic [23:0] EH_DATA_LEN   = 24'h000200
) (
	input  wire logic          clk,
	input  wire logic          sys_rst,
	input  wire logic          ce,
	input  wire logic [AW-1:0] s_axi_awaddr,
	input  wire logic          s_axi_awvalid,
	output logic               s_axi_awready,
	input  wire logic [31:0]   s_axi_wdata,
	input  wire logic [3:0]    s_axi_wstrb,
	input  wire logic          s_axi_wvalid,
	output logic               s_axi_wready,
	output logic [1:0]         s_axi_bresp,
	output logic               s_axi_bvalid,
	input  wire logic          s_axi_bready,
	input  wire logic [AW-1:0] s_axi_araddr,
	input  wire logic          s_axi_arvalid,
	output logic               s_axi_arready,
	output logic [31:0]        s_axi_rdata,
	output logic [1:0]         s_axi_rresp,
	output logic               s_axi_rvalid,
	input  wire logic          s_axi_rready
);
	localparam int EIW = $clog2(ECHO_WORDS);
	localparam logic [15:0] ECHO_CAP = 16'(ECHO_WORDS * 4);

	// byte-lane merge for partial writes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (st[i])
				r[i*8 +: 8] = nw[i*8 +: 8];
		return r;
	endfunction

	function automatic logic [23:0] min24(input logic [23:0] a, input logic [23:0] b);
		return (a < b) ? a : b;
	endfunction

	logic [31:0]    cdbR;
	logic [23:0]    offsetR;
	logic [23:0]    allocR;
	logic [7:0]     nexusR;
	logic           doneR;
	logic           checkR;
	logic [3:0]     keyR;
	logic [7:0]     ascR;
	logic [7:0]     ascqR;
	logic [23:0]    xferR;
	logic [31:0]    descWordR;
	logic [31:0]    echoMem [ECHO_WORDS];
	logic [EIW-1:0] echoWrIdxR;
	logic [EIW-1:0] echoRdIdxR;
	logic [15:0]    echoLenR;
	logic           echoValidR;
	logic           ownerValidR;
	logic           snapR;
	logic [7:0]     ownerR;
	logic [4:0]     readModeR;

	logic [4:0]  mode;
	logic [7:0]  bufId;
	logic        wrFire;
	logic        rdFire;
	logic [7:0]  wrAddr;
	logic [7:0]  rdAddr;
	logic        startFire;
	logic        dataRead;
	logic        chk;
	logic [7:0]  asc;
	logic [7:0]  ascq;
	logic [23:0] xfer;
	logic [31:0] dataW;
	logic        setSnap;
	logic        clrSnap;
	logic        setOwner;
	logic        clrOwner;
	logic        constrained;
	logic        foreign;
	logic [31:0] rdVal;
	logic        rdHit;

	assign mode      = cdbR[rbm_pkg::CDB_MODE_LSB +: 5];
	assign bufId     = cdbR[rbm_pkg::CDB_ID_LSB +: 8];
	assign wrAddr    = 8'(s_axi_awaddr);
	assign rdAddr    = 8'(s_axi_araddr);
	// address and data are taken together in the same handshake cycle
	assign wrFire    = ce && s_axi_awready && s_axi_awvalid && s_axi_wvalid;
	assign rdFire    = ce && s_axi_arready && s_axi_arvalid;
	assign startFire = wrFire && wrAddr == rbm_pkg::OFF_CTRL && s_axi_wdata[rbm_pkg::CTRL_START] && s_axi_wstrb[0];
	assign dataRead  = rdFire && rdAddr == rbm_pkg::OFF_DATA;
	assign constrained = !(bufId == rbm_pkg::EH_ANY_LO || bufId == rbm_pkg::EH_DIR_LAST);
	assign foreign     = ownerValidR && nexusR != ownerR;

	// command decode: outcome of one command, taken at the start strobe
	always_comb
	begin
		chk      = 1'b0;
		asc      = rbm_pkg::ASC_INV_FIELD;
		ascq     = rbm_pkg::ASCQ_NONE;
		xfer     = rbm_pkg::ZERO24;
		dataW    = 32'h00000000;
		setSnap  = 1'b0;
		clrSnap  = 1'b0;
		setOwner = 1'b0;
		clrOwner = 1'b0;
		case (mode)
			rbm_pkg::MODE_DESC:
			begin
				dataW = {rbm_pkg::OFFSET_BOUNDARY, DBUF_CAPACITY};
				if (allocR != rbm_pkg::ZERO24 && allocR < rbm_pkg::DESC_LEN)
					chk = 1'b1;
				else
					xfer = min24(allocR, rbm_pkg::DESC_LEN);
			end
			// id and offset ignored; only the last allocation byte counts
			rbm_pkg::MODE_ECHO, rbm_pkg::MODE_EXPANDER:
			begin
				if (!echoValidR)
				begin
					chk = 1'b1;
					asc = rbm_pkg::ASC_SEQ_ERR;
				end
				else
					xfer = min24({16'h0000, allocR[7:0]}, {8'h00, echoLenR});
			end
			rbm_pkg::MODE_ECHO_DESC:
			begin
				dataW = {16'h0000, 3'h0, ECHO_CAP[12:0] & rbm_pkg::ECHO_CAP_ALIGN};
				dataW[rbm_pkg::ECHO_OVERWRITE_SUPPORTED_FLAG_POS] = rbm_pkg::ECHO_OVERWRITE;
				if (offsetR != rbm_pkg::ZERO24)
					chk = 1'b1;
				else
					xfer = min24(allocR, rbm_pkg::DESC_LEN);
			end
			rbm_pkg::MODE_ERRHIST:
			begin
				if (constrained && foreign)
				begin
					chk  = 1'b1;
					asc  = rbm_pkg::ASC_OP_PROG;
					ascq = rbm_pkg::ASCQ_OP_PROG;
				end
				else if (bufId <= rbm_pkg::EH_DIR_LAST)
				begin
					if (offsetR != rbm_pkg::ZERO24)
						chk = 1'b1;
					else
					begin
						xfer     = min24(allocR, EH_DIR_LEN);
						setSnap  = bufId[0];
						setOwner = bufId[1];
					end
				end
				else if (bufId >= rbm_pkg::EH_DATA_LO && bufId <= rbm_pkg::EH_DATA_HI)
				begin
					// offsets past the stored history cannot be served
					if (offsetR > rbm_pkg::EH_OFF_MAX || offsetR >= EH_DATA_LEN)
						chk = 1'b1;
					else
						xfer = min24(allocR, EH_DATA_LEN - offsetR);
				end
				else if (bufId == rbm_pkg::EH_CLR_NEXUS || bufId == rbm_pkg::EH_CLR_ALL)
				begin
					clrOwner = 1'b1;
					clrSnap  = bufId[0];
				end
				else
					chk = 1'b1;
			end
			default:
				chk = 1'b1;
		endcase
	end

	// command result registers
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			doneR     <= 1'b0;
			checkR    <= 1'b0;
			keyR      <= rbm_pkg::SK_NONE;
			ascR      <= rbm_pkg::ASC_NONE;
			ascqR     <= rbm_pkg::ASCQ_NONE;
			xferR     <= rbm_pkg::ZERO24;
			descWordR <= 32'h00000000;
			readModeR <= 5'h00;
		end
		else if (startFire)
		begin
			doneR     <= 1'b1;
			checkR    <= chk;
			keyR      <= chk ? rbm_pkg::SK_ILLEGAL : rbm_pkg::SK_NONE;
			ascR      <= chk ? asc : rbm_pkg::ASC_NONE;
			ascqR     <= chk ? ascq : rbm_pkg::ASCQ_NONE;
			xferR     <= chk ? rbm_pkg::ZERO24 : xfer;
			descWordR <= dataW;
			readModeR <= mode;
		end
	end

	// error history ownership; a failed command leaves it untouched
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			ownerValidR <= 1'b0;
			snapR       <= 1'b0;
			ownerR      <= 8'h00;
		end
		else if (startFire && !chk)
		begin
			if (setOwner)
			begin
				ownerValidR <= 1'b1;
				ownerR      <= nexusR;
			end
			else if (clrOwner)
				ownerValidR <= 1'b0;
			if (setSnap)
				snapR <= 1'b1;
			else if (clrSnap)
				snapR <= 1'b0;
		end
	end

	// echo storage, apart from the data buffer, filled by the echo write path
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			echoWrIdxR <= '0;
			echoLenR   <= 16'h0000;
			echoValidR <= 1'b0;
		end
		else if (wrFire && wrAddr == rbm_pkg::OFF_ECHOWR)
			echoWrIdxR <= echoWrIdxR + 1'b1;
		else if (wrFire && wrAddr == rbm_pkg::OFF_ECHOLEN)
		begin
			// bytes beyond capacity would be indeterminate, so clamp
			echoLenR   <= (s_axi_wdata[15:0] > ECHO_CAP) ? ECHO_CAP : s_axi_wdata[15:0];
			echoValidR <= 1'b1;
			echoWrIdxR <= '0;
		end
	end

	// memory has no reset: contents are undefined until written
	always_ff @(posedge clk)
	begin
		if (wrFire && wrAddr == rbm_pkg::OFF_ECHOWR)
			echoMem[echoWrIdxR] <= merge(echoMem[echoWrIdxR], s_axi_wdata, s_axi_wstrb);
	end

	// echo read pointer restarts with each command and advances per data read after an echo or expander command
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			echoRdIdxR <= '0;
		else if (startFire)
			echoRdIdxR <= '0;
		else if (dataRead && (readModeR == rbm_pkg::MODE_ECHO || readModeR == rbm_pkg::MODE_EXPANDER))
			echoRdIdxR <= echoRdIdxR + 1'b1;
	end

	// command field registers
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			cdbR    <= 32'h00000000;
			offsetR <= rbm_pkg::ZERO24;
			allocR  <= rbm_pkg::ZERO24;
			nexusR  <= 8'h00;
		end
		else if (wrFire)
		begin
			if (wrAddr == rbm_pkg::OFF_CDB)
				cdbR <= merge(cdbR, s_axi_wdata, s_axi_wstrb) & 32'h0000FF1F;
			if (wrAddr == rbm_pkg::OFF_OFFSET)
				offsetR <= 24'(merge({8'h00, offsetR}, s_axi_wdata, s_axi_wstrb));
			if (wrAddr == rbm_pkg::OFF_ALLOC)
				allocR <= 24'(merge({8'h00, allocR}, s_axi_wdata, s_axi_wstrb));
			if (wrAddr == rbm_pkg::OFF_NEXUS)
				nexusR <= 8'(merge({24'h000000, nexusR}, s_axi_wdata, s_axi_wstrb));
		end
	end

	// read mux; unmapped addresses answer SLVERR with zero data
	always_comb
	begin
		rdHit = 1'b1;
		rdVal = 32'h00000000;
		case (rdAddr)
			rbm_pkg::OFF_CDB:     rdVal = cdbR;
			rbm_pkg::OFF_OFFSET:  rdVal = {8'h00, offsetR};
			rbm_pkg::OFF_ALLOC:   rdVal = {8'h00, allocR};
			rbm_pkg::OFF_NEXUS:   rdVal = {24'h000000, nexusR};
			rbm_pkg::OFF_CTRL:    rdVal = 32'h00000000;
			rbm_pkg::OFF_STATUS:  rdVal = {ascR, ascqR, 4'h0, keyR, 6'h00, checkR, doneR};
			rbm_pkg::OFF_XFER:    rdVal = {8'h00, xferR};
			rbm_pkg::OFF_DATA:
				rdVal = (readModeR == rbm_pkg::MODE_ECHO || readModeR == rbm_pkg::MODE_EXPANDER)
					? echoMem[echoRdIdxR] : descWordR;
			rbm_pkg::OFF_ECHOLEN: rdVal = {15'h0000, echoValidR, echoLenR};
			rbm_pkg::OFF_EHSTATE: rdVal = {16'h0000, ownerR, 6'h00, snapR, ownerValidR};
			default:              rdHit = 1'b0;
		endcase
	end

	// write channel: ready pulses one cycle once both address and data wait
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= rbm_pkg::RESP_OKAY;
		end
		else if (ce)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			if (wrFire)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (wrAddr > rbm_pkg::OFF_EHSTATE || wrAddr[1:0] != 2'h0) ? rbm_pkg::RESP_SLVERR
					: rbm_pkg::RESP_OKAY;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			else if (!s_axi_bvalid && !s_axi_awready && s_axi_awvalid && s_axi_wvalid)
			begin
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// read channel: one read outstanding at a time
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= rbm_pkg::RESP_OKAY;
		end
		else if (ce)
		begin
			s_axi_arready <= 1'b0;
			if (rdFire)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rdVal;
				s_axi_rresp  <= rdHit ? rbm_pkg::RESP_OKAY : rbm_pkg::RESP_SLVERR;
			end
			else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
			else if (!s_axi_rvalid && !s_axi_arready && s_axi_arvalid)
				s_axi_arready <= 1'b1;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	sequence s_start(logic [4:0] m);
		startFire && mode == m;
	endsequence

	sequence s_wr_taken;
		wrFire;
	endsequence

	property p_desc_len;
		s_start(rbm_pkg::MODE_DESC) ##0 (allocR >= rbm_pkg::DESC_LEN) |=> !checkR && xferR == rbm_pkg::DESC_LEN;
	endproperty
	a_desc_len: assert property (p_desc_len) else $error("descriptor length not four");

	property p_desc_zero;
		s_start(rbm_pkg::MODE_DESC) ##0 (allocR == rbm_pkg::ZERO24) |=> doneR && !checkR && xferR == rbm_pkg::ZERO24;
	endproperty
	a_desc_zero: assert property (p_desc_zero) else $error("zero allocation moved data");

	property p_desc_short;
		s_start(rbm_pkg::MODE_DESC) ##0 (allocR > rbm_pkg::ZERO24 && allocR < rbm_pkg::DESC_LEN)
			|=> checkR && keyR == rbm_pkg::SK_ILLEGAL && ascR == rbm_pkg::ASC_INV_FIELD;
	endproperty
	a_desc_short: assert property (p_desc_short) else $error("short allocation not rejected");

	property p_desc_word;
		s_start(rbm_pkg::MODE_DESC) |=> descWordR[31:24] == rbm_pkg::OFFSET_BOUNDARY && descWordR[23:0] == DBUF_CAPACITY;
	endproperty
	a_desc_word: assert property (p_desc_word) else $error("descriptor contents wrong");

	property p_echo_none;
		s_start(rbm_pkg::MODE_ECHO) ##0 !echoValidR |=> checkR && keyR == rbm_pkg::SK_ILLEGAL && xferR == rbm_pkg::ZERO24;
	endproperty
	a_echo_none: assert property (p_echo_none) else $error("echo read without write accepted");

	property p_echo_len;
		(s_start(rbm_pkg::MODE_ECHO) or s_start(rbm_pkg::MODE_EXPANDER)) ##0 echoValidR
			|=> xferR == min24({16'h0000, $past(allocR[7:0])}, {8'h00, echoLenR});
	endproperty
	a_echo_len: assert property (p_echo_len) else $error("echo transfer length wrong");

	property p_echo_desc;
		s_start(rbm_pkg::MODE_ECHO_DESC) ##0 (offsetR != rbm_pkg::ZERO24) |=> checkR && ascR == rbm_pkg::ASC_INV_FIELD;
	endproperty
	a_echo_desc: assert property (p_echo_desc) else $error("echo descriptor offset not checked");

	property p_eh_busy;
		s_start(rbm_pkg::MODE_ERRHIST) ##0 (constrained && foreign && snapR)
			|=> checkR && ascqR == rbm_pkg::ASCQ_OP_PROG && snapR && ownerR == $past(ownerR);
	endproperty
	a_eh_busy: assert property (p_eh_busy) else $error("foreign nexus not refused");

	property p_eh_clear;
		s_start(rbm_pkg::MODE_ERRHIST) ##0 (bufId == rbm_pkg::EH_CLR_ALL && !foreign) |=> !ownerValidR && !snapR;
	endproperty
	a_eh_clear: assert property (p_eh_clear) else $error("nexus or snapshot not released");

	property p_eh_reserved;
		s_start(rbm_pkg::MODE_ERRHIST) ##0 (!foreign && bufId >= 8'h04 && bufId <= 8'h0F) |=> checkR && ascR == 8'h24;
	endproperty
	a_eh_reserved: assert property (p_eh_reserved) else $error("reserved id accepted");

	property p_wr_resp;
		s_wr_taken |=> s_axi_bvalid ##0 !s_axi_awready;
	endproperty
	a_wr_resp: assert property (p_wr_resp) else $error("write response missing");
endmodule
`default_nettype wire

//--- rbm_read_buffer_test.sv
// self-checking bench for the read-buffer command handler
`default_nettype none
module rbm_read_buffer_test;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic [4:0]  mode;
		logic [7:0]  id;
		logic [23:0] off;
		logic [23:0] alloc;
		logic [7:0]  nex;
		logic [31:0] st;
		logic [31:0] xf;
		logic [31:0] dat;
		logic        hasDat;
	} rbm_row_type;
	localparam logic [23:0] DBUF    = 24'h000800;
	localparam logic [31:0] ST_OK   = 32'h00000001;
	localparam logic [31:0] ST_INV  = {rbm_pkg::ASC_INV_FIELD, rbm_pkg::ASCQ_NONE, 4'h0, rbm_pkg::SK_ILLEGAL, 8'h03};
	localparam logic [31:0] ST_PROG = {rbm_pkg::ASC_OP_PROG, rbm_pkg::ASCQ_OP_PROG, 4'h0, rbm_pkg::SK_ILLEGAL, 8'h03};
	localparam logic [31:0] ST_SEQ  = {rbm_pkg::ASC_SEQ_ERR, rbm_pkg::ASCQ_NONE, 4'h0, rbm_pkg::SK_ILLEGAL, 8'h03};
	localparam logic [31:0] DESC_W  = {rbm_pkg::OFFSET_BOUNDARY, DBUF};
	localparam logic [4:0]  DSC     = rbm_pkg::MODE_DESC;
	localparam logic [4:0]  EDSC    = rbm_pkg::MODE_ECHO_DESC;
	localparam logic [4:0]  EH      = rbm_pkg::MODE_ERRHIST;
	logic        clk;
	logic        sysRst;
	logic        ce;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, v;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, r;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	int          errors;
	int          nTests;
	int          cycles;
	// ordinary cases: command fields beside status, count and first data word
	rbm_row_type rows [14] = '{
		'{DSC, 8'h00, 24'h0, 24'h0, 8'h01, ST_OK, 32'h0, 32'h0, 1'b0},
		'{DSC, 8'h00, 24'h0, 24'h1, 8'h01, ST_INV, 32'h0, 32'h0, 1'b0},
		'{DSC, 8'h00, 24'h0, 24'h3, 8'h01, ST_INV, 32'h0, 32'h0, 1'b0},
		'{DSC, 8'h00, 24'h0, 24'h4, 8'h01, ST_OK, 32'h4, DESC_W, 1'b1},
		'{DSC, 8'h00, 24'h0, 24'h100, 8'h01, ST_OK, 32'h4, DESC_W, 1'b1},
		'{EDSC, 8'h00, 24'h0, 24'h2, 8'h01, ST_OK, 32'h2, 32'h40, 1'b1},
		'{EDSC, 8'h00, 24'h0, 24'h9, 8'h01, ST_OK, 32'h4, 32'h40, 1'b1},
		'{EDSC, 8'h00, 24'h4, 24'h4, 8'h01, ST_INV, 32'h0, 32'h0, 1'b0},
		'{5'h00, 8'h00, 24'h0, 24'h4, 8'h01, ST_INV, 32'h0, 32'h0, 1'b0},
		'{EH, 8'h04, 24'h0, 24'h10, 8'h01, ST_INV, 32'h0, 32'h0, 1'b0},
		'{EH, 8'hFD, 24'h0, 24'h10, 8'h01, ST_INV, 32'h0, 32'h0, 1'b0},
		'{EH, 8'h00, 24'h4, 24'h10, 8'h01, ST_INV, 32'h0, 32'h0, 1'b0},
		'{EH, 8'h10, 24'h200, 24'h10, 8'h01, ST_INV, 32'h0, 32'h0, 1'b0},
		'{EH, 8'h10, 24'h1F0, 24'h100, 8'h01, ST_OK, 32'h10, 32'h0, 1'b0}
	};

	rbm_read_buffer #(
		.AW            (8),
		.ECHO_WORDS    (16),
		.DBUF_CAPACITY (DBUF),
		.EH_DIR_LEN    (24'h000028),
		.EH_DATA_LEN   (24'h000200)
	) i_dut (
		.clk           (clk),
		.sys_rst       (sysRst),
		.ce            (ce),
		.s_axi_awaddr  (awaddr),
		.s_axi_awvalid (awvalid),
		.s_axi_awready (awready),
		.s_axi_wdata   (wdata),
		.s_axi_wstrb   (wstrb),
		.s_axi_wvalid  (wvalid),
		.s_axi_wready  (wready),
		.s_axi_bresp   (bresp),
		.s_axi_bvalid  (bvalid),
		.s_axi_bready  (bready),
		.s_axi_araddr  (araddr),
		.s_axi_arvalid (arvalid),
		.s_axi_arready (arready),
		.s_axi_rdata   (rdata),
		.s_axi_rresp   (rresp),
		.s_axi_rvalid  (rvalid),
		.s_axi_rready  (rready)
	);

	rbm_host_model i_host (
		.clk     (clk),
		.awaddr  (awaddr),
		.awvalid (awvalid),
		.awready (awready),
		.wdata   (wdata),
		.wstrb   (wstrb),
		.wvalid  (wvalid),
		.wready  (wready),
		.bresp   (bresp),
		.bvalid  (bvalid),
		.bready  (bready),
		.araddr  (araddr),
		.arvalid (arvalid),
		.arready (arready),
		.rdata   (rdata),
		.rresp   (rresp),
		.rvalid  (rvalid),
		.rready  (rready)
	);

	// 25 MHz clock
	always #20 clk = ~clk;

	// hang guard: a full run needs under a thousand cycles
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			errors++;
			report_and_stop();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		nTests++;
		if (seen !== exp)
		begin
			errors++;
			$display("[FAIL] %0t mismatch seen %h expected %h", $time, seen, exp);
		end
	endtask

	// masked register read, so state bits can be checked alone
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
		i_host.rd(a, v, r);
		check(v & m, exp);
	endtask

	task automatic run(input rbm_row_type t);
		logic [31:0] st;
		logic [31:0] xf;
		i_host.cmd(t.mode, t.id, t.off, t.alloc, t.nex, st, xf);
		check(st, t.st);
		check(xf, t.xf);
		if (t.hasDat)
		begin
			i_host.rd(rbm_pkg::OFF_DATA, v, r);
			check(v, t.dat);
		end
		$display("test mode %h id %h done", t.mode, t.id);
	endtask

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", nTests, errors);
		if (errors == 0 && nTests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// main sequence
	initial
	begin
		clk = 1'b0;
		sysRst = 1'b1;
		ce = 1'b1;
		errors = 0;
		nTests = 0;
		cycles = 0;
		repeat (3) @(posedge clk);
		sysRst <= 1'b0;
		// reset values, read-only write, unmapped place
		rchk(rbm_pkg::OFF_ECHOLEN, 32'h0, '1);
		rchk(rbm_pkg::OFF_EHSTATE, 32'h0, '1);
		i_host.wr(rbm_pkg::OFF_STATUS, 32'hFFFFFFFF, r);
		check({30'h0, r}, {30'h0, rbm_pkg::RESP_OKAY});
		rchk(rbm_pkg::OFF_STATUS, 32'h0, '1);
		i_host.wr(8'h40, 32'h1, r);
		check({30'h0, r}, {30'h0, rbm_pkg::RESP_SLVERR});
		i_host.rd(8'h40, v, r);
		check({r, v[29:0]}, {rbm_pkg::RESP_SLVERR, 30'h0});
		$display("bus test done");
		foreach (rows[i])
			run(rows[i]);
		// echo traffic: refused before loading, then both length limits
		run('{rbm_pkg::MODE_ECHO, 8'h00, 24'h0, 24'h10, 8'h01, ST_SEQ, 32'h0, 32'h0, 1'b0});
		i_host.echo_load(32'hA1B2C3D4, 32'h5E6F7081, 16'h0007);
		rchk(rbm_pkg::OFF_ECHOLEN, 32'h00010007, '1);
		run('{rbm_pkg::MODE_ECHO, 8'h07, 24'h35, 24'hFF0006, 8'h01, ST_OK, 32'h6, 32'hA1B2C3D4, 1'b1});
		i_host.rd(rbm_pkg::OFF_DATA, v, r);
		check(v, 32'h5E6F7081);
		run('{rbm_pkg::MODE_EXPANDER, 8'h00, 24'h0, 24'h20, 8'h01, ST_OK, 32'h7, 32'hA1B2C3D4, 1'b1});
		run('{DSC, 8'h00, 24'h0, 24'h4, 8'h01, ST_OK, 32'h4, DESC_W, 1'b1});
		// error history ownership: take, refuse a stranger, hand over, clear
		run('{EH, 8'h03, 24'h0, 24'h100, 8'h01, ST_OK, 32'h28, 32'h0, 1'b0});
		rchk(rbm_pkg::OFF_EHSTATE, 32'h0103, 32'hFFFF);
		run('{EH, 8'h00, 24'h0, 24'h100, 8'h02, ST_PROG, 32'h0, 32'h0, 1'b0});
		run('{EH, 8'h10, 24'h0, 24'h100, 8'h02, ST_PROG, 32'h0, 32'h0, 1'b0});
		run('{EH, 8'h01, 24'h0, 24'h100, 8'h01, ST_OK, 32'h28, 32'h0, 1'b0});
		run('{EH, 8'h02, 24'h0, 24'h100, 8'h02, ST_OK, 32'h28, 32'h0, 1'b0});
		rchk(rbm_pkg::OFF_EHSTATE, 32'h0203, 32'hFFFF);
		run('{EH, 8'hFE, 24'h123, 24'h100, 8'h02, ST_OK, 32'h0, 32'h0, 1'b0});
		rchk(rbm_pkg::OFF_EHSTATE, 32'h2, 32'h3);
		run('{EH, 8'hFF, 24'h77, 24'h100, 8'h01, ST_OK, 32'h0, 32'h0, 1'b0});
		rchk(rbm_pkg::OFF_EHSTATE, 32'h0, 32'h3);
		// second reset mid-run forgets the echo load
		sysRst <= 1'b1;
		repeat (3) @(posedge clk);
		sysRst <= 1'b0;
		rchk(rbm_pkg::OFF_ECHOLEN, 32'h0, '1);
		// clock enable low: a pending read must not be answered until it returns
		ce <= 1'b0;
		fork
			i_host.rd(rbm_pkg::OFF_STATUS, v, r);
			begin
				repeat (5) @(posedge clk);
				check({30'h0, arready, rvalid}, 32'h0);
				ce <= 1'b1;
			end
		join
		check(v, 32'h0);
		$display("clock enable test done");
		run('{rbm_pkg::MODE_ECHO, 8'h00, 24'h0, 24'h10, 8'h01, ST_SEQ, 32'h0, 32'h0, 1'b0});
		report_and_stop();
	end
endmodule
`default_nettype wire
